/* inc/pef_pkg.sv */
// Package with command codes, field layout and reset values of the event flag bank
package pef_pkg;

  // Channel count and field widths
  localparam int unsigned NUM_CH   = 4;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned DET_RES_W = 4;
  localparam int unsigned CLS_RES_W = 4;

  // Command codes: read-only view and clear-on-read view of each register
  localparam logic [CODE_W-1:0] CMD_DISC_VIEW   = 8'h04;
  localparam logic [CODE_W-1:0] CMD_DISC_CLEAR  = 8'h05;
  localparam logic [CODE_W-1:0] CMD_FAULT_VIEW  = 8'h06;
  localparam logic [CODE_W-1:0] CMD_FAULT_CLEAR = 8'h07;
  localparam logic [CODE_W-1:0] CMD_START_VIEW  = 8'h08;
  localparam logic [CODE_W-1:0] CMD_START_CLEAR = 8'h09;

  // Nibble positions inside every event register
  localparam int unsigned HI_NIB_LSB = 4;
  localparam int unsigned LO_NIB_LSB = 0;

  // Reset values
  localparam logic [NUM_CH-1:0] FLAGS_RST   = 4'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RST = 8'h00;
  localparam logic [DET_RES_W-1:0] DET_RES_RST = 4'h0;
  localparam logic [CLS_RES_W-1:0] CLS_RES_RST = 4'h0;

  // Operating mode encodings of the controller
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_SEMI   = 2'h1;
  localparam logic [1:0] MODE_AUTO   = 2'h3;

endpackage : pef_pkg

/* rtl/pef_event_flags.sv */
// Per-channel discovery, fault and start/limit event flags with command read port and interrupt pin
`timescale 1ns/1ps

module pef_event_flags (
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // Command port from the serial management interface
  input  wire logic                              cmd_rd,
  input  wire logic [pef_pkg::CODE_W-1:0]        cmd_code,
  output logic      [pef_pkg::DATA_W-1:0]        rd_data_q,
  output logic                                   rd_valid_q,
  output logic                                   rd_hit_q,
  // Configuration levels
  input  wire logic                              class_change_report_en,
  input  wire logic                              detect_change_report_en,
  input  wire logic                              global_irq_enable,
  input  wire logic                              cls_irq_mask,
  input  wire logic                              det_irq_mask,
  input  wire logic                              disc_irq_mask,
  input  wire logic                              fault_irq_mask,
  input  wire logic                              start_irq_mask,
  input  wire logic [1:0]                        op_mode,
  input  wire logic [pef_pkg::NUM_CH/2-1:0]      four_pair_port,
  input  wire logic [pef_pkg::NUM_CH/2-1:0]      dual_signature,
  input  wire logic [pef_pkg::NUM_CH-1:0]        power_on_request,
  // Per-channel event pulses from the analog and discovery engines
  input  wire logic [pef_pkg::NUM_CH-1:0]        det_done,
  input  wire logic [pef_pkg::NUM_CH*pef_pkg::DET_RES_W-1:0] det_result,
  input  wire logic [pef_pkg::NUM_CH-1:0]        cls_done,
  input  wire logic [pef_pkg::NUM_CH*pef_pkg::CLS_RES_W-1:0] cls_result,
  input  wire logic [pef_pkg::NUM_CH-1:0]        disconnect_evt,
  input  wire logic [pef_pkg::NUM_CH-1:0]        overload_timeout_evt,
  input  wire logic [pef_pkg::NUM_CH-1:0]        current_limit_evt,
  input  wire logic [pef_pkg::NUM_CH-1:0]        start_fault_evt,
  input  wire logic [pef_pkg::NUM_CH-1:0]        chan_off,
  // Interrupt pin and summary levels
  output logic                                   int_n_q,
  output logic                                   sum_discovery_q,
  output logic                                   sum_fault_q,
  output logic                                   sum_start_q
);
  import pef_pkg::*;

  // Flag storage, one bit per channel per field
  logic [NUM_CH-1:0] class_event_flag_q;
  logic [NUM_CH-1:0] detect_event_flag_q;
  logic [NUM_CH-1:0] disconnect_flag_q;
  logic [NUM_CH-1:0] overload_cut_flag_q;
  logic [NUM_CH-1:0] current_limit_fault_flag_q;
  logic [NUM_CH-1:0] start_fault_flag_q;

  // Held-back completions for paired channels
  logic [NUM_CH-1:0] det_pend_q;
  logic [NUM_CH-1:0] det_pend_d;
  logic [NUM_CH-1:0] cls_pend_q;
  logic [NUM_CH-1:0] cls_pend_d;

  // Last results, for change reporting
  logic [DET_RES_W-1:0] det_prev_q [NUM_CH];
  logic [CLS_RES_W-1:0] cls_prev_q [NUM_CH];

  // Per-channel set terms
  logic [NUM_CH-1:0] det_hit;
  logic [NUM_CH-1:0] cls_hit;
  logic [NUM_CH-1:0] det_set;
  logic [NUM_CH-1:0] cls_set;
  logic [NUM_CH-1:0] disc_set;
  logic [NUM_CH-1:0] det_group;
  logic [NUM_CH-1:0] cls_group;

  // Clear-on-read strobes
  logic clr_disc;
  logic clr_fault;
  logic clr_start;

  assign clr_disc  = cmd_rd && (cmd_code == CMD_DISC_CLEAR);
  assign clr_fault = cmd_rd && (cmd_code == CMD_FAULT_CLEAR);
  assign clr_start = cmd_rd && (cmd_code == CMD_START_CLEAR);

  // Per-channel qualification of discovery and disconnect events
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam int unsigned PEER = i ^ 1;
    localparam int unsigned PORT = i / 2;
    logic [DET_RES_W-1:0] det_now;
    logic [CLS_RES_W-1:0] cls_now;
    assign det_now = det_result[i*DET_RES_W +: DET_RES_W];
    assign cls_now = cls_result[i*CLS_RES_W +: CLS_RES_W];

    // any completed cycle counts; only a changed result
    assign det_hit[i] = det_done[i] && (!detect_change_report_en || (det_now != det_prev_q[i]));
    // any completed cycle counts; only a changed class
    assign cls_hit[i] = cls_done[i] && (!class_change_report_en || (cls_now != cls_prev_q[i]));

    // paired port with no pending request; auto dual-signature stays per channel
    assign det_group[i] = four_pair_port[PORT] && !power_on_request[i] && !power_on_request[PEER]
                          && !(dual_signature[PORT] && (op_mode == MODE_AUTO));
    // dual-signature semi-auto only; leave other cases per channel
    assign cls_group[i] = four_pair_port[PORT] && dual_signature[PORT] && (op_mode == MODE_SEMI)
                          && !power_on_request[i] && !power_on_request[PEER];

    // both channels released in the cycle the second one completes
    assign det_set[i] = det_group[i]
                        ? ((det_pend_q[i] || det_hit[i]) && (det_pend_q[PEER] || det_hit[PEER]))
                        : det_hit[i];
    // class flags released together in dual-signature semi-auto; otherwise per channel
    assign cls_set[i] = cls_group[i]
                        ? ((cls_pend_q[i] || cls_hit[i]) && (cls_pend_q[PEER] || cls_hit[PEER]))
                        : cls_hit[i];

    // single-signature disconnect mirrors onto the partner channel
    assign disc_set[i] = disconnect_evt[i]
                         || (four_pair_port[PORT] && !dual_signature[PORT] && disconnect_evt[PEER]);

    // Pending bits: kept until the pair releases, the grouping ends or the channel turns off
    always_comb begin
      det_pend_d[i] = det_pend_q[i];
      cls_pend_d[i] = cls_pend_q[i];
      if (det_group[i] && det_hit[i]) begin
        det_pend_d[i] = 1'b1;
      end
      if (cls_group[i] && cls_hit[i]) begin
        cls_pend_d[i] = 1'b1;
      end
      // grouping dropped once the pair has reported or the mode no longer pairs
      if (det_set[i] || !det_group[i] || chan_off[i]) begin
        det_pend_d[i] = 1'b0;
      end
      if (cls_set[i] || !cls_group[i] || chan_off[i]) begin
        cls_pend_d[i] = 1'b0;
      end
    end

    // Result history for change reporting
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        det_prev_q[i] <= DET_RES_RST;
        cls_prev_q[i] <= CLS_RES_RST;
      end else begin
        if (det_done[i]) begin
          det_prev_q[i] <= det_now;
        end
        if (cls_done[i]) begin
          cls_prev_q[i] <= cls_now;
        end
      end
    end
  end

  // Pending registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      det_pend_q <= FLAGS_RST;
      cls_pend_q <= FLAGS_RST;
    end else begin
      det_pend_q <= det_pend_d;
      cls_pend_q <= cls_pend_d;
    end
  end

  // Discovery flags; a set in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      class_event_flag_q  <= FLAGS_RST;
      detect_event_flag_q <= FLAGS_RST;
    end else begin
      // turn-off and clear-on-read both lose against a new set
      // turn-off is per channel, so a re-powered partner keeps its flags
      class_event_flag_q  <= ((clr_disc ? FLAGS_RST : class_event_flag_q) & ~chan_off) | cls_set;
      detect_event_flag_q <= ((clr_disc ? FLAGS_RST : detect_event_flag_q) & ~chan_off) | det_set;
    end
  end

  // Fault flags; timers live elsewhere so clearing touches only the flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disconnect_flag_q   <= FLAGS_RST;
      overload_cut_flag_q <= FLAGS_RST;
    end else begin
      disconnect_flag_q   <= ((clr_fault ? FLAGS_RST : disconnect_flag_q) & ~chan_off) | disc_set;
      // overload timeout flagged whether or not cut is enabled
      overload_cut_flag_q <= ((clr_fault ? FLAGS_RST : overload_cut_flag_q) & ~chan_off)
                             | overload_timeout_evt;
    end
  end

  // Start and current-limit flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_limit_fault_flag_q <= FLAGS_RST;
      start_fault_flag_q         <= FLAGS_RST;
    end else begin
      current_limit_fault_flag_q <= ((clr_start ? FLAGS_RST : current_limit_fault_flag_q) & ~chan_off)
                                    | current_limit_evt;
      // start-time or class/detect error during turn-on
      start_fault_flag_q         <= ((clr_start ? FLAGS_RST : start_fault_flag_q) & ~chan_off)
                                    | start_fault_evt;
    end
  end

  // Read answer one cycle after the command; data is the value before any clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q  <= RD_DATA_RST;
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end else begin
      rd_valid_q <= cmd_rd;
      rd_hit_q   <= 1'b0;
      rd_data_q  <= RD_DATA_RST;
      if (cmd_rd) begin
        // channel n sits at bit n of each nibble
        case (cmd_code)
          CMD_DISC_VIEW, CMD_DISC_CLEAR: begin
            rd_data_q <= {class_event_flag_q, detect_event_flag_q};
            rd_hit_q  <= 1'b1;
          end
          CMD_FAULT_VIEW, CMD_FAULT_CLEAR: begin
            rd_data_q <= {disconnect_flag_q, overload_cut_flag_q};
            rd_hit_q  <= 1'b1;
          end
          CMD_START_VIEW, CMD_START_CLEAR: begin
            rd_data_q <= {current_limit_fault_flag_q, start_fault_flag_q};
            rd_hit_q  <= 1'b1;
          end
          default: begin
            rd_data_q <= RD_DATA_RST;
          end
        endcase
      end
    end
  end

  // Summary levels and interrupt pin, from the settled flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_discovery_q <= 1'b0;
      sum_fault_q     <= 1'b0;
      sum_start_q     <= 1'b0;
      int_n_q         <= 1'b1;
    end else begin
      // any set bit feeds the summary
      sum_discovery_q <= |{class_event_flag_q, detect_event_flag_q};
      sum_fault_q     <= |{disconnect_flag_q, overload_cut_flag_q};
      sum_start_q     <= |{current_limit_fault_flag_q, start_fault_flag_q};
      // pin low while an enabled flag is set; released once reads clear them
      int_n_q <= !(global_irq_enable &&
                   ((cls_irq_mask   && |class_event_flag_q) ||
                    (det_irq_mask   && |detect_event_flag_q) ||
                    (disc_irq_mask  && |disconnect_flag_q) ||
                    (fault_irq_mask && |{overload_cut_flag_q, current_limit_fault_flag_q}) ||
                    (start_irq_mask && |start_fault_flag_q)));
    end
  end

endmodule : pef_event_flags

/* bench/pef_event_flags_checker.sv */
// Assertions on the event flag bank ports
`timescale 1ns/1ps
module pef_event_flags_checker (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        cmd_rd,
  input wire logic [pef_pkg::CODE_W-1:0]  cmd_code,
  input wire logic [pef_pkg::DATA_W-1:0]  rd_data_q,
  input wire logic                        rd_valid_q,
  input wire logic                        rd_hit_q,
  input wire logic                        global_irq_enable,
  input wire logic                        fault_irq_mask,
  input wire logic [pef_pkg::NUM_CH-1:0]  disconnect_evt,
  input wire logic [pef_pkg::NUM_CH-1:0]  overload_timeout_evt,
  input wire logic [pef_pkg::NUM_CH-1:0]  start_fault_evt,
  input wire logic [pef_pkg::NUM_CH-1:0]  chan_off,
  input wire logic                        int_n_q,
  input wire logic                        sum_fault_q
);
  import pef_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic quiet;
  // No fault event that could refill the fault register
  assign quiet = (disconnect_evt == 4'h0) && (overload_timeout_evt == 4'h0);
  sequence s_read(logic [7:0] c);
    cmd_rd && cmd_code == c;
  endsequence
  // Clear-on-read, then a view read two cycles on
  sequence s_clear_then_view;
    s_read(CMD_FAULT_CLEAR) ##0 quiet ##1 quiet ##1 quiet ##0 s_read(CMD_FAULT_VIEW);
  endsequence
  a_answer_next: assert property (cmd_rd |=> rd_valid_q)
    else $error("read answer missing");
  a_miss_zero: assert property (rd_valid_q && !rd_hit_q |-> rd_data_q == 8'h00)
    else $error("unmapped read returned data");
  a_hit_mapped: assert property (cmd_rd && cmd_code inside {[8'h04:8'h09]} |=> rd_hit_q)
    else $error("mapped code not hit");
  a_clear_empties: assert property (s_clear_then_view |=> rd_data_q == 8'h00)
    else $error("fault register not cleared");
  a_overload_seen: assert property (overload_timeout_evt[0] ##1 !(cmd_rd && cmd_code == CMD_FAULT_CLEAR) &&
    !chan_off[0] ##1 s_read(CMD_FAULT_VIEW) |=> rd_data_q[0]) else $error("overload flag missing");
  a_start_seen: assert property (start_fault_evt[1] ##1 !(cmd_rd && cmd_code == CMD_START_CLEAR) &&
    !chan_off[1] ##1 s_read(CMD_START_VIEW) |=> rd_data_q[1]) else $error("start flag missing");
  a_sum_fault: assert property (overload_timeout_evt != 4'h0 |-> ##2 sum_fault_q)
    else $error("fault summary not raised");
  a_pin_raise: assert property (overload_timeout_evt != 4'h0 ##0 (fault_irq_mask && global_irq_enable)[*3]
    |-> !int_n_q) else $error("interrupt pin not asserted");
  a_pin_gate: assert property (!global_irq_enable |=> int_n_q)
    else $error("interrupt pin low while disabled");
endmodule : pef_event_flags_checker

/* bench/pef_host.sv */
// Host model issuing single register read commands
`timescale 1ns/1ps
module pef_host (
  input  wire logic [0:0]                 clk,
  output logic                            cmd_rd,
  output logic [pef_pkg::CODE_W-1:0]      cmd_code,
  input  wire logic [pef_pkg::DATA_W-1:0] rd_data_q,
  input  wire logic                       rd_valid_q,
  input  wire logic                       rd_hit_q
);
  initial begin
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
  end
  // One-cycle strobe; a longer one would clear the register twice
  task automatic read(input logic [7:0] code, output logic [7:0] data, output logic hit);
    @(posedge clk);
    #1 cmd_rd = 1'b1;
    cmd_code = code;
    @(posedge clk);
    #1 cmd_rd = 1'b0;
    cmd_code = ~code;  // Stale code must not matter
    data = rd_valid_q ? rd_data_q : 8'hXX;
    hit = rd_hit_q;
  endtask : read
endmodule : pef_host

/* bench/pef_event_flags_test.sv */
// Self-checking bench for the event flag bank
`timescale 1ns/1ps
module pef_event_flags_test;
  import pef_pkg::*;
  logic        clk, rst_n, cmd_rd, rd_valid_q, rd_hit_q, int_n_q, sum_discovery_q, sum_fault_q, sum_start_q;
  logic        class_change_report_en, detect_change_report_en, global_irq_enable, fault_irq_mask;
  logic        cls_irq_mask, det_irq_mask, disc_irq_mask, start_irq_mask;
  logic [1:0]  op_mode, four_pair_port, dual_signature;
  logic [3:0]  power_on_request, det_done, cls_done, disconnect_evt, overload_timeout_evt;
  logic [3:0]  current_limit_evt, start_fault_evt, chan_off;
  logic [7:0]  cmd_code, rd_data_q;
  logic [15:0] det_result, cls_result;
  logic [27:0] evts;
  int          errors, checked;

  // Event groups packed so one pulse task reaches all of them
  assign {chan_off, start_fault_evt, current_limit_evt, overload_timeout_evt, disconnect_evt, cls_done, det_done} = evts;
  pef_event_flags u_pef_event_flags (.*);
  pef_host u_pef_host (.*);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    logic [7:0] d;
    logic       h;
    u_pef_host.read(code, d, h);
    chk("read hit", {7'h00, h}, {7'h00, code >= 8'h04 && code <= 8'h09});
    chk("read data", d, exp);
  endtask : rd

  // Group k: 0 det, 1 cls, 2 disc, 3 ovl, 4 lim, 5 start, 6 off
  task automatic ev(input int k, input logic [3:0] m);
    @(posedge clk);
    #1 evts = 28'(m) << (4 * k);
    @(posedge clk);
    #1 evts = 28'h0000000;
  endtask : ev

  task automatic pin(input logic [7:0] exp);
    repeat (2) @(posedge clk);
    #1 chk("interrupt pin", {7'h00, int_n_q}, exp);
  endtask : pin

  task automatic wrap_up;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Watchdog far beyond the 130 or so cycles the tests need
  initial begin
    #1000000;
    errors++;
    wrap_up();
  end

  initial begin
    {rst_n, class_change_report_en, detect_change_report_en, global_irq_enable, fault_irq_mask} = 5'h00;
    {cls_irq_mask, det_irq_mask, disc_irq_mask, start_irq_mask} = 4'h0;
    {op_mode, four_pair_port, dual_signature, power_on_request} = 10'h000;
    {evts, det_result, cls_result} = 60'h0;
    errors = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int c = 4; c < 11; c++) rd(8'(c), 8'h00);
    ev(2, 4'h4);
    ev(3, 4'h1);
    rd(CMD_FAULT_VIEW, 8'h41);
    rd(CMD_FAULT_CLEAR, 8'h41);
    rd(CMD_FAULT_VIEW, 8'h00);
    ev(4, 4'h8);
    ev(5, 4'h2);
    rd(CMD_START_VIEW, 8'h82);
    chk("start summary", {7'h00, sum_start_q}, 8'h01);
    rd(CMD_START_CLEAR, 8'h82);
    rd(CMD_START_VIEW, 8'h00);
    chk("start summary", {7'h00, sum_start_q}, 8'h00);
    fault_irq_mask = 1'b1;
    global_irq_enable = 1'b1;
    ev(3, 4'h2);
    pin(8'h00);
    chk("fault summary", {7'h00, sum_fault_q}, 8'h01);
    rd(CMD_FAULT_CLEAR, 8'h02);
    pin(8'h01);
    global_irq_enable = 1'b0;
    ev(3, 4'h4);
    pin(8'h01);
    rd(CMD_FAULT_CLEAR, 8'h04);
    ev(2, 4'h2);
    ev(6, 4'h2);
    rd(CMD_FAULT_VIEW, 8'h00);
    det_result = 16'h0500;
    cls_result = 16'h0300;
    ev(0, 4'h4);
    ev(1, 4'h4);
    rd(CMD_DISC_CLEAR, 8'h44);
    {class_change_report_en, detect_change_report_en} = 2'h3;
    ev(0, 4'h4);
    ev(1, 4'h4);
    rd(CMD_DISC_VIEW, 8'h00);
    det_result = 16'h0600;
    ev(0, 4'h4);
    rd(CMD_DISC_CLEAR, 8'h04);
    {class_change_report_en, detect_change_report_en} = 2'h0;
    four_pair_port = 2'h1;
    ev(0, 4'h1);
    rd(CMD_DISC_VIEW, 8'h00);
    ev(0, 4'h2);
    rd(CMD_DISC_CLEAR, 8'h03);
    ev(1, 4'h1);
    rd(CMD_DISC_CLEAR, 8'h10);
    ev(2, 4'h1);
    rd(CMD_FAULT_CLEAR, 8'h30);
    power_on_request = 4'h3;
    ev(0, 4'h1);
    rd(CMD_DISC_CLEAR, 8'h01);
    // Dual-signature semi-auto: class flags wait for both channels
    power_on_request = 4'h0;
    dual_signature = 2'h1;
    op_mode = MODE_SEMI;
    cls_irq_mask = 1'b1;
    global_irq_enable = 1'b1;
    ev(1, 4'h1);
    rd(CMD_DISC_VIEW, 8'h00);
    ev(1, 4'h2);
    pin(8'h00);
    rd(CMD_DISC_VIEW, 8'h30);
    chk("discovery summary", {7'h00, sum_discovery_q}, 8'h01);
    rd(CMD_DISC_CLEAR, 8'h30);
    pin(8'h01);
    // Auto mode dual-signature: detection per channel, own mask off
    op_mode = MODE_AUTO;
    ev(0, 4'h1);
    pin(8'h01);
    rd(CMD_DISC_CLEAR, 8'h01);
    wrap_up();
  end
endmodule : pef_event_flags_test

bind pef_event_flags pef_event_flags_checker u_pef_event_flags_checker (.*);
